// File: rtl/energy_meter_config_regs.sv
// Indirectly addressed configuration and peak register bank of the energy engine
module energy_meter_config_regs #(
	parameter int PEAK_W = 24
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire meas_regs_pkg::peak_in_t current_peak,
	input wire meas_regs_pkg::peak_in_t voltage_peak,
	output meas_regs_pkg::meas_cfg_t cfg,
	output meas_regs_pkg::mode_t mode,
	output logic meas_soft_reset
);
	logic [15:0] cfg_r [meas_regs_pkg::CFG_DEPTH];
	logic [23:0] data_r;
	logic [23:0] data_nxt;
	logic [7:0] ptr_r;
	logic [7:0] sfr_rdata_r;
	logic [7:0] sfr_rdata_nxt;
	logic soft_reset_r;
	logic [PEAK_W-1:0] cur_hold_w;
	logic [PEAK_W-1:0] volt_hold_w;

	wire ptr_wr_w;
	wire commit_w;
	wire fetch_w;
	wire soft_rst_w;
	wire [6:0] ptr_addr_w;
	wire [23:0] fetch_val_w;
	wire [7:0] sfr_sel_w;
	wire cur_clear_w;
	wire volt_clear_w;
	wire is_cur_peak_w;
	wire is_volt_peak_w;

	if (PEAK_W < 1 || PEAK_W > meas_regs_pkg::DATA_W) begin : g_bad_peak
		$error("energy_meter_config_regs: peak width must fit the data bytes");
	end

	// Pointer write: bit 7 set commits data bytes, clear fetches into them
	assign ptr_wr_w = sfr_wr && sfr_addr == meas_regs_pkg::SFR_POINTER; // R22
	assign ptr_addr_w = sfr_wdata[meas_regs_pkg::PTR_W-1:0]; // R22
	assign commit_w = ptr_wr_w && sfr_wdata[meas_regs_pkg::PTR_CMD_BIT]; // R22
	assign fetch_w = ptr_wr_w && !sfr_wdata[meas_regs_pkg::PTR_CMD_BIT]; // R22
	assign soft_rst_w = commit_w && ptr_addr_w == meas_regs_pkg::ADDR_MODE
		&& data_r[meas_regs_pkg::MODE_SOFT_RESET_BIT]; // R15

	assign is_cur_peak_w = ptr_addr_w == meas_regs_pkg::ADDR_CUR_PK_HOLD
		|| ptr_addr_w == meas_regs_pkg::ADDR_CUR_PK_CLEAR; // R5
	assign is_volt_peak_w = ptr_addr_w == meas_regs_pkg::ADDR_VOLT_PK_HOLD
		|| ptr_addr_w == meas_regs_pkg::ADDR_VOLT_PK_CLEAR; // R6
	// Unused locations hold constant zero, so the plain path reads them as zero
	assign fetch_val_w = is_cur_peak_w ? 24'(cur_hold_w)
		: is_volt_peak_w ? 24'(volt_hold_w)
		: {8'h00, cfg_r[ptr_addr_w]}; // R23

	assign cur_clear_w = soft_rst_w
		|| (fetch_w && ptr_addr_w == meas_regs_pkg::ADDR_CUR_PK_CLEAR); // R5 R15
	assign volt_clear_w = soft_rst_w
		|| (fetch_w && ptr_addr_w == meas_regs_pkg::ADDR_VOLT_PK_CLEAR); // R6 R15

	assign data_nxt = fetch_w ? fetch_val_w
		: (sfr_wr && sfr_addr == meas_regs_pkg::SFR_DATA_LOW) ? {data_r[23:8], sfr_wdata}
		: (sfr_wr && sfr_addr == meas_regs_pkg::SFR_DATA_MID) ? {data_r[23:16], sfr_wdata, data_r[7:0]}
		: (sfr_wr && sfr_addr == meas_regs_pkg::SFR_DATA_HIGH) ? {sfr_wdata, data_r[15:0]}
		: data_r; // R22

	assign sfr_sel_w = (sfr_addr == meas_regs_pkg::SFR_POINTER) ? ptr_r
		: (sfr_addr == meas_regs_pkg::SFR_DATA_LOW) ? data_r[7:0]
		: (sfr_addr == meas_regs_pkg::SFR_DATA_MID) ? data_r[15:8]
		: (sfr_addr == meas_regs_pkg::SFR_DATA_HIGH) ? data_r[23:16]
		: 8'h00;
	assign sfr_rdata_nxt = sfr_rd ? sfr_sel_w : sfr_rdata_r;

	// One flop set per location; unmapped ones have zero mask and fold away
	for (genvar g = 0; g < meas_regs_pkg::CFG_DEPTH; g++) begin : g_cfg
		localparam logic [6:0] A = 7'(g);
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				cfg_r[g] <= meas_regs_pkg::cfg_default(A);
			end else if (soft_rst_w) begin
				cfg_r[g] <= meas_regs_pkg::cfg_default(A); // R15
			end else if (commit_w && ptr_addr_w == A) begin
				cfg_r[g] <= data_r[15:0] & meas_regs_pkg::cfg_mask(A); // R23
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			data_r <= '0;
			ptr_r <= 8'h00;
			sfr_rdata_r <= 8'h00;
			soft_reset_r <= 1'b0;
		end else begin
			data_r <= data_nxt;
			ptr_r <= ptr_wr_w ? sfr_wdata : ptr_r;
			sfr_rdata_r <= sfr_rdata_nxt;
			soft_reset_r <= soft_rst_w;
		end
	end

	peak_hold #(
		.W(PEAK_W)
	) u_cur_peak (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.sample(current_peak.value[PEAK_W-1:0]),
		.sample_valid(current_peak.valid),
		.clear(cur_clear_w),
		.hold_r(cur_hold_w)
	);

	peak_hold #(
		.W(PEAK_W)
	) u_volt_peak (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.sample(voltage_peak.value[PEAK_W-1:0]),
		.sample_valid(voltage_peak.valid),
		.clear(volt_clear_w),
		.hold_r(volt_hold_w)
	);

	assign sfr_rdata = sfr_rdata_r;
	assign meas_soft_reset = soft_reset_r; // R15
	// Mode bits drive the datapath directly, one flop each
	assign mode = meas_regs_pkg::mode_t'(cfg_r[meas_regs_pkg::ADDR_MODE][7:0]); // R16 R17 R18 R19 R20 R21

	assign cfg.line_accum_half_cycles = cfg_r[meas_regs_pkg::ADDR_LINE_ACCUM]; // R1
	assign cfg.sag_half_cycles = cfg_r[meas_regs_pkg::ADDR_DIP_CYCLES][7:0]; // R2
	assign cfg.sag_threshold = cfg_r[meas_regs_pkg::ADDR_DIP_THRESH]; // R3
	assign cfg.current_peak_threshold = cfg_r[meas_regs_pkg::ADDR_CUR_PK_THRESH]; // R4
	assign cfg.voltage_peak_threshold = cfg_r[meas_regs_pkg::ADDR_VOLT_PK_THRESH]; // R4
	assign cfg.input_amp_setting = cfg_r[meas_regs_pkg::ADDR_AMP][7:0];
	assign cfg.second_current_match = cfg_r[meas_regs_pkg::ADDR_SECOND_MATCH][11:0]; // R8
	assign cfg.active_power_scale = cfg_r[meas_regs_pkg::ADDR_ACTIVE_SCALE][11:0]; // R7
	assign cfg.reactive_power_scale = cfg_r[meas_regs_pkg::ADDR_REACTIVE_SCALE][11:0]; // R7
	assign cfg.apparent_power_scale = cfg_r[meas_regs_pkg::ADDR_APPARENT_SCALE][11:0]; // R7
	assign cfg.active_power_offset = cfg_r[meas_regs_pkg::ADDR_ACTIVE_OFFSET]; // R9
	assign cfg.reactive_power_offset = cfg_r[meas_regs_pkg::ADDR_REACTIVE_OFFSET]; // R9
	assign cfg.current_rms_offset = cfg_r[meas_regs_pkg::ADDR_CUR_RMS_OFFSET][11:0]; // R10
	assign cfg.voltage_rms_offset = cfg_r[meas_regs_pkg::ADDR_VOLT_RMS_OFFSET][11:0]; // R10
	assign cfg.active_energy_divider = cfg_r[meas_regs_pkg::ADDR_ACTIVE_DIV][7:0]; // R11
	assign cfg.reactive_energy_divider = cfg_r[meas_regs_pkg::ADDR_REACTIVE_DIV][7:0]; // R11
	assign cfg.apparent_energy_divider = cfg_r[meas_regs_pkg::ADDR_APPARENT_DIV][7:0]; // R11
	assign cfg.pulse_out1_numerator = cfg_r[meas_regs_pkg::ADDR_PULSE1_NUM]; // R12
	assign cfg.pulse_out1_denominator = cfg_r[meas_regs_pkg::ADDR_PULSE1_DEN]; // R12
	assign cfg.pulse_out2_numerator = cfg_r[meas_regs_pkg::ADDR_PULSE2_NUM]; // R12
	assign cfg.pulse_out2_denominator = cfg_r[meas_regs_pkg::ADDR_PULSE2_DEN]; // R12
	assign cfg.zero_cross_output_cfg = cfg_r[meas_regs_pkg::ADDR_ZERO_CROSS][7:0]; // R13
	assign cfg.calibration_select = cfg_r[meas_regs_pkg::ADDR_CAL_SELECT][7:0];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_soft_reset_defaults: assert property (soft_rst_w |=> cfg.line_accum_half_cycles == 16'hFFFF // R15
		&& cfg.pulse_out1_denominator == 16'h003F && mode == 8'h06 && meas_soft_reset)
		else $error("soft reset did not restore defaults");
	a_line_accum_write: assert property (commit_w && ptr_addr_w == meas_regs_pkg::ADDR_LINE_ACCUM // R1
		|=> cfg.line_accum_half_cycles == 16'($past(data_r)))
		else $error("line span write lost");
	a_dip_cycles_width: assert property (commit_w && ptr_addr_w == meas_regs_pkg::ADDR_DIP_CYCLES // R2
		|=> cfg_r[meas_regs_pkg::ADDR_DIP_CYCLES] == {8'h00, 8'($past(data_r))})
		else $error("dip duration not 8 bits");
	a_dip_thresh_write: assert property (commit_w && ptr_addr_w == meas_regs_pkg::ADDR_DIP_THRESH // R3
		|=> cfg.sag_threshold == 16'($past(data_r)))
		else $error("dip threshold write lost");
	a_volt_thresh_apart: assert property (commit_w && ptr_addr_w == meas_regs_pkg::ADDR_CUR_PK_THRESH // R4
		|=> $stable(cfg.voltage_peak_threshold))
		else $error("peak thresholds not separate");
	a_gain_twelve_bits: assert property (commit_w && ptr_addr_w == meas_regs_pkg::ADDR_ACTIVE_SCALE // R7
		|=> cfg_r[meas_regs_pkg::ADDR_ACTIVE_SCALE] == {4'h0, 12'($past(data_r))})
		else $error("gain not 12 bits");
	a_cur_peak_keep: assert property (fetch_w && ptr_addr_w == meas_regs_pkg::ADDR_CUR_PK_HOLD // R5
		&& !current_peak.valid |=> $stable(cur_hold_w) && data_r == 24'($past(cur_hold_w)))
		else $error("keeping read changed current peak");
	a_volt_peak_clear: assert property (fetch_w && ptr_addr_w == meas_regs_pkg::ADDR_VOLT_PK_CLEAR // R6
		&& !voltage_peak.valid |=> volt_hold_w == '0 && data_r == 24'($past(volt_hold_w)))
		else $error("clearing read failed on voltage peak");
	a_mode_write: assert property (commit_w && ptr_addr_w == meas_regs_pkg::ADDR_MODE // R16 R17 R18 R19 R20 R21
		&& !data_r[meas_regs_pkg::MODE_SOFT_RESET_BIT] |=> mode == 8'($past(data_r)))
		else $error("mode bits not taken");
	a_readonly_ignored: assert property (commit_w && ptr_addr_w == meas_regs_pkg::ADDR_CUR_PK_HOLD // R23
		|=> cfg_r[meas_regs_pkg::ADDR_CUR_PK_HOLD] == 16'h0000)
		else $error("read-only location took a write");
	a_unused_reads_zero: assert property (fetch_w && meas_regs_pkg::cfg_mask(ptr_addr_w) == '0 // R23
		&& !is_cur_peak_w && !is_volt_peak_w |=> data_r == 24'h000000)
		else $error("unused location read nonzero");
	a_byte_readback: assert property (sfr_rd && sfr_addr == meas_regs_pkg::SFR_DATA_MID // R22
		|=> sfr_rdata == $past(data_r[15:8]))
		else $error("middle data byte readback wrong");

	c_commit: cover property (commit_w && ptr_addr_w == meas_regs_pkg::ADDR_PULSE1_NUM);
	c_fetch_clear: cover property (fetch_w && ptr_addr_w == meas_regs_pkg::ADDR_CUR_PK_CLEAR && current_peak.valid);
	c_soft_reset: cover property (soft_rst_w);
	c_fetch_then_read: cover property (fetch_w ##2 sfr_rd && sfr_addr == meas_regs_pkg::SFR_DATA_LOW);
endmodule : energy_meter_config_regs

// File: rtl/meas_regs_pkg.sv
// Constants, types and decode tables of the energy measurement register bank
// Overview of operation
// (R1) Line-synchronous accumulation span: 16-bit half-cycle count, resets to 0xFFFF.
// (R2) Voltage dip duration: 8-bit half-cycle count, resets to 0xFF.
// (R3) Voltage dip threshold: 16-bit unsigned, resets to zero.
// (R4) Separate 16-bit current and voltage peak thresholds, both reset to 0xFFFF.
// (R5) Current peak readable at two locations: one keeps it, one clears it after reading.
// (R6) Voltage peak readable at two locations: one keeps it, one clears it after reading.
// (R7) 12-bit signed active, reactive and apparent power gains, reset to zero.
// (R8) 12-bit signed matching gain for second current input, reset to zero.
// (R9) 16-bit signed active and reactive power offsets, reset to zero.
// (R10) 12-bit signed current and voltage rms offsets, reset to zero.
// (R11) Three 8-bit energy scaling dividers, reset to zero.
// (R12) Per pulse output: 16-bit numerator reset zero, 16-bit denominator reset 0x003F.
// (R13) 8-bit zero-crossing output enable register, reset to zero.
// (R14) Software keeps reserved locations at reset values; one of them resets to 0x0300.
// (R15) Writing one to mode bit 7 returns all measurement registers to reset values.
// (R16) Mode bit 6 bypasses the zero-crossing low-pass filter.
// (R17) Mode bit 5 inserts the current-path integrator.
// (R18) Mode bit 4 exchanges the two channel converter outputs.
// (R19) Mode bit 3 powers down both converters.
// (R20) Mode bits 2 and 1 disable the pulse outputs; both reset to one.
// (R21) Mode bit 0 bypasses the high-pass filters in both channels.
// (R22) Access is indirect: 7-bit location via pointer, data via low, mid, high bytes.
// (R23) Writes to read-only or unused locations do nothing; unused locations read zero.
package meas_regs_pkg;
	localparam int PTR_W = 7;
	localparam int DATA_W = 24;
	localparam int CFG_W = 16;
	localparam int CFG_DEPTH = 2 ** PTR_W;
	localparam int PTR_CMD_BIT = 7;
	localparam int MODE_SOFT_RESET_BIT = 7;

	localparam logic [7:0] SFR_POINTER = 8'h91;
	localparam logic [7:0] SFR_DATA_LOW = 8'h92;
	localparam logic [7:0] SFR_DATA_MID = 8'h93;
	localparam logic [7:0] SFR_DATA_HIGH = 8'h94;

	localparam logic [6:0] ADDR_MODE = 7'h0B;
	localparam logic [6:0] ADDR_LINE_ACCUM = 7'h12;
	localparam logic [6:0] ADDR_DIP_CYCLES = 7'h13;
	localparam logic [6:0] ADDR_DIP_THRESH = 7'h14;
	localparam logic [6:0] ADDR_CUR_PK_THRESH = 7'h15;
	localparam logic [6:0] ADDR_VOLT_PK_THRESH = 7'h16;
	localparam logic [6:0] ADDR_CUR_PK_HOLD = 7'h17;
	localparam logic [6:0] ADDR_CUR_PK_CLEAR = 7'h18;
	localparam logic [6:0] ADDR_VOLT_PK_HOLD = 7'h19;
	localparam logic [6:0] ADDR_VOLT_PK_CLEAR = 7'h1A;
	localparam logic [6:0] ADDR_AMP = 7'h1B;
	localparam logic [6:0] ADDR_SECOND_MATCH = 7'h1C;
	localparam logic [6:0] ADDR_ACTIVE_SCALE = 7'h1D;
	localparam logic [6:0] ADDR_REACTIVE_SCALE = 7'h1E;
	localparam logic [6:0] ADDR_APPARENT_SCALE = 7'h1F;
	localparam logic [6:0] ADDR_ACTIVE_OFFSET = 7'h20;
	localparam logic [6:0] ADDR_REACTIVE_OFFSET = 7'h21;
	localparam logic [6:0] ADDR_CUR_RMS_OFFSET = 7'h22;
	localparam logic [6:0] ADDR_VOLT_RMS_OFFSET = 7'h23;
	localparam logic [6:0] ADDR_ACTIVE_DIV = 7'h24;
	localparam logic [6:0] ADDR_REACTIVE_DIV = 7'h25;
	localparam logic [6:0] ADDR_APPARENT_DIV = 7'h26;
	localparam logic [6:0] ADDR_PULSE1_NUM = 7'h27;
	localparam logic [6:0] ADDR_PULSE1_DEN = 7'h28;
	localparam logic [6:0] ADDR_PULSE2_NUM = 7'h29;
	localparam logic [6:0] ADDR_PULSE2_DEN = 7'h2A;
	localparam logic [6:0] ADDR_ZERO_CROSS = 7'h2B;
	localparam logic [6:0] ADDR_RSV_3B = 7'h3B;
	localparam logic [6:0] ADDR_RSV_3C = 7'h3C;
	localparam logic [6:0] ADDR_CAL_SELECT = 7'h3D;
	localparam logic [6:0] ADDR_RSV_3E = 7'h3E;
	localparam logic [6:0] ADDR_RSV_3F = 7'h3F;

	localparam logic [15:0] MASK_8 = 16'h00FF;
	localparam logic [15:0] MASK_12 = 16'h0FFF;
	localparam logic [15:0] MASK_16 = 16'hFFFF;
	localparam logic [15:0] MODE_DEFAULT = 16'h0006;
	localparam logic [15:0] LINE_ACCUM_DEFAULT = 16'hFFFF;
	localparam logic [15:0] DIP_CYCLES_DEFAULT = 16'h00FF;
	localparam logic [15:0] PK_THRESH_DEFAULT = 16'hFFFF;
	localparam logic [15:0] PULSE_DEN_DEFAULT = 16'h003F;
	localparam logic [15:0] RSV_3C_DEFAULT = 16'h0300;
	localparam logic [15:0] ZERO_DEFAULT = 16'h0000;

	// Bit order matches the register, bit 7 first
	typedef struct packed {
		logic soft_reset_bit;
		logic zero_cross_filter_bypass;
		logic integrator_on;
		logic channel_exchange;
		logic converter_sleep;
		logic pulse_out2_off;
		logic pulse_out1_off;
		logic highpass_bypass;
	} mode_t;

	typedef struct packed {
		logic valid;
		logic [23:0] value;
	} peak_in_t;

	typedef struct packed {
		logic [15:0] line_accum_half_cycles;
		logic [7:0] sag_half_cycles;
		logic [15:0] sag_threshold;
		logic [15:0] current_peak_threshold;
		logic [15:0] voltage_peak_threshold;
		logic [7:0] input_amp_setting;
		logic [11:0] second_current_match;
		logic [11:0] active_power_scale;
		logic [11:0] reactive_power_scale;
		logic [11:0] apparent_power_scale;
		logic [15:0] active_power_offset;
		logic [15:0] reactive_power_offset;
		logic [11:0] current_rms_offset;
		logic [11:0] voltage_rms_offset;
		logic [7:0] active_energy_divider;
		logic [7:0] reactive_energy_divider;
		logic [7:0] apparent_energy_divider;
		logic [15:0] pulse_out1_numerator;
		logic [15:0] pulse_out1_denominator;
		logic [15:0] pulse_out2_numerator;
		logic [15:0] pulse_out2_denominator;
		logic [7:0] zero_cross_output_cfg;
		logic [7:0] calibration_select;
	} meas_cfg_t;

	// Writable bits per location; zero marks read-only or unused
	function automatic logic [15:0] cfg_mask(input logic [6:0] a);
		case (a)
			ADDR_MODE, ADDR_DIP_CYCLES, ADDR_AMP, ADDR_ZERO_CROSS, ADDR_CAL_SELECT: cfg_mask = MASK_8; // R2 R13
			ADDR_ACTIVE_DIV, ADDR_REACTIVE_DIV, ADDR_APPARENT_DIV: cfg_mask = MASK_8; // R11
			ADDR_RSV_3B, ADDR_RSV_3E, ADDR_RSV_3F: cfg_mask = MASK_8; // R14
			ADDR_SECOND_MATCH, ADDR_ACTIVE_SCALE, ADDR_REACTIVE_SCALE, ADDR_APPARENT_SCALE: cfg_mask = MASK_12; // R7 R8
			ADDR_CUR_RMS_OFFSET, ADDR_VOLT_RMS_OFFSET: cfg_mask = MASK_12; // R10
			ADDR_LINE_ACCUM, ADDR_DIP_THRESH, ADDR_CUR_PK_THRESH, ADDR_VOLT_PK_THRESH: cfg_mask = MASK_16; // R1 R3 R4
			ADDR_ACTIVE_OFFSET, ADDR_REACTIVE_OFFSET, ADDR_RSV_3C: cfg_mask = MASK_16; // R9 R14
			ADDR_PULSE1_NUM, ADDR_PULSE1_DEN, ADDR_PULSE2_NUM, ADDR_PULSE2_DEN: cfg_mask = MASK_16; // R12
			default: cfg_mask = ZERO_DEFAULT; // R23
		endcase
	endfunction : cfg_mask

	function automatic logic [15:0] cfg_default(input logic [6:0] a);
		case (a)
			ADDR_MODE: cfg_default = MODE_DEFAULT; // R20
			ADDR_LINE_ACCUM: cfg_default = LINE_ACCUM_DEFAULT; // R1
			ADDR_DIP_CYCLES: cfg_default = DIP_CYCLES_DEFAULT; // R2
			ADDR_CUR_PK_THRESH, ADDR_VOLT_PK_THRESH: cfg_default = PK_THRESH_DEFAULT; // R4
			ADDR_PULSE1_DEN, ADDR_PULSE2_DEN: cfg_default = PULSE_DEN_DEFAULT; // R12
			ADDR_RSV_3C: cfg_default = RSV_3C_DEFAULT; // R14
			default: cfg_default = ZERO_DEFAULT;
		endcase
	endfunction : cfg_default
endpackage : meas_regs_pkg

// File: rtl/peak_hold.sv
// Captured peak magnitude with keep and clear-on-read access
module peak_hold #(
	parameter int W = 24
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [W-1:0] sample,
	input wire logic sample_valid,
	input wire logic clear,
	output logic [W-1:0] hold_r
);
	logic [W-1:0] hold_nxt;
	logic take_w;

	if (W < 1) begin : g_bad_width
		$error("peak_hold: width must be positive");
	end

	// A sample in the clear cycle is kept, so no peak is lost to a read
	assign take_w = sample_valid && (clear || sample > hold_r);
	assign hold_nxt = take_w ? sample : (clear ? '0 : hold_r);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hold_r <= '0;
		end else begin
			hold_r <= hold_nxt;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_clear_to_zero: assert property (clear && !sample_valid |=> hold_r == '0) // R5
		else $error("peak not cleared");
	a_peak_grows: assert property (sample_valid && sample > hold_r |=> hold_r == $past(sample)) // R6
		else $error("larger sample not captured");
	a_peak_keeps: assert property (!sample_valid && !clear |=> $stable(hold_r)) // R5
		else $error("peak changed without cause");
endmodule : peak_hold

// File: testbench/sfr_core_model.sv
// Processor core model driving the SFR window of the register bank
module sfr_core_model (
	input wire logic clk_sys,
	output logic [7:0] sfr_addr,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	// One SFR cycle; released address and data go inverse so stale values never look valid
	task automatic sfr_op(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys);
		#1;
		sfr_addr = a;
		sfr_wr = w;
		sfr_rd = !w;
		sfr_wdata = d;
		@(posedge clk_sys);
		#1;
		q = sfr_rdata;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~d;
	endtask : sfr_op
	task automatic reg_write(input logic [6:0] a, input logic [23:0] v);
		logic [7:0] q;
		sfr_op(8'h92, 1'b1, v[7:0], q);
		sfr_op(8'h93, 1'b1, v[15:8], q);
		sfr_op(8'h94, 1'b1, v[23:16], q);
		sfr_op(8'h91, 1'b1, {1'b1, a}, q);
	endtask : reg_write
	task automatic reg_read(input logic [6:0] a, output logic [23:0] v);
		sfr_op(8'h91, 1'b1, {1'b0, a}, v[7:0]);
		sfr_op(8'h92, 1'b0, 8'h00, v[7:0]);
		sfr_op(8'h93, 1'b0, 8'h00, v[15:8]);
		sfr_op(8'h94, 1'b0, 8'h00, v[23:16]);
	endtask : reg_read
endmodule : sfr_core_model

// File: testbench/testbench.sv
// Self-checking bench of the energy measurement register bank
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, resetn, sfr_wr, sfr_rd, meas_soft_reset;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, q;
	meas_regs_pkg::peak_in_t current_peak, voltage_peak;
	meas_regs_pkg::meas_cfg_t cfg;
	meas_regs_pkg::mode_t mode;
	int failures, num_checks, pulses, seed, v;
	int exp_reg[128];
	int pk[2];
	logic [23:0] got;

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (meas_soft_reset === 1'b1) pulses++;

	energy_meter_config_regs energy_meter_config_regs_inst (.clk_sys(clk_sys), .resetn(resetn),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.current_peak(current_peak), .voltage_peak(voltage_peak), .cfg(cfg), .mode(mode),
		.meas_soft_reset(meas_soft_reset));
	sfr_core_model sfr_core_model_inst (.clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

	// Writable bits of each location, zero where nothing is stored
	function automatic int wmask(int a);
		if (a inside {7'h0B, 7'h13, 7'h1B, [7'h24:7'h26], 7'h2B, 7'h3B, [7'h3D:7'h3F]}) return 16'h00FF;
		if (a inside {[7'h1C:7'h1F], 7'h22, 7'h23}) return 16'h0FFF;
		if (a inside {7'h12, [7'h14:7'h16], 7'h20, 7'h21, [7'h27:7'h2A], 7'h3C}) return 16'hFFFF;
		return 0;
	endfunction : wmask
	function automatic int dflt(int a);
		case (a)
			7'h0B: return 16'h0006;
			7'h12, 7'h15, 7'h16: return 16'hFFFF;
			7'h13: return 16'h00FF;
			7'h28, 7'h2A: return 16'h003F;
			7'h3C: return 16'h0300;
			default: return 0;
		endcase
	endfunction : dflt
	task automatic chk_val(logic [23:0] g, logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_val
	task automatic chk_out(logic [15:0] g, logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t port=%h exp=%h", $time, g, e);
		end
	endtask : chk_out
	task automatic chk_cfg();
		meas_regs_pkg::meas_cfg_t e;
		e = {exp_reg[7'h12][15:0], exp_reg[7'h13][7:0], exp_reg[7'h14][15:0], exp_reg[7'h15][15:0],
			exp_reg[7'h16][15:0], exp_reg[7'h1B][7:0], exp_reg[7'h1C][11:0], exp_reg[7'h1D][11:0],
			exp_reg[7'h1E][11:0], exp_reg[7'h1F][11:0], exp_reg[7'h20][15:0], exp_reg[7'h21][15:0],
			exp_reg[7'h22][11:0], exp_reg[7'h23][11:0], exp_reg[7'h24][7:0], exp_reg[7'h25][7:0],
			exp_reg[7'h26][7:0], exp_reg[7'h27][15:0], exp_reg[7'h28][15:0], exp_reg[7'h29][15:0],
			exp_reg[7'h2A][15:0], exp_reg[7'h2B][7:0], exp_reg[7'h3D][7:0]};
		for (int i = 0; i < 18; i++) chk_out(cfg[16 * i +: 16], e[16 * i +: 16]);
	endtask : chk_cfg
	task automatic expect_reg(int a);
		int e;
		e = (a == 7'h17 || a == 7'h18) ? pk[0] : (a == 7'h19 || a == 7'h1A) ? pk[1] : exp_reg[a];
		sfr_core_model_inst.reg_read(a[6:0], got);
		chk_val(got, e[23:0]);
		if (a == 7'h18) pk[0] = 0;
		if (a == 7'h1A) pk[1] = 0;
	endtask : expect_reg
	task automatic sweep();
		for (int a = 0; a < 128; a++) expect_reg(a);
	endtask : sweep
	task automatic put(int a, int d);
		sfr_core_model_inst.reg_write(a[6:0], d[23:0]);
		exp_reg[a] = d & wmask(a);
	endtask : put
	task automatic drive_peak(int ch, logic [23:0] d);
		@(posedge clk_sys);
		#1;
		if (ch == 0) current_peak = {1'b1, d};
		else voltage_peak = {1'b1, d};
		@(posedge clk_sys);
		#1;
		current_peak = {1'b0, ~current_peak.value};
		voltage_peak = {1'b0, ~voltage_peak.value};
		if (d > pk[ch]) pk[ch] = d;
	endtask : drive_peak
	task automatic finish_test();
		if (failures == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	initial begin
		seed = 37024;
		failures = 0;
		num_checks = 0;
		pulses = 0;
		resetn = 1'b0;
		current_peak = '0;
		voltage_peak = '0;
		for (int a = 0; a < 128; a++) exp_reg[a] = dflt(a);
		pk[0] = 0;
		pk[1] = 0;
		repeat (5) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		chk_out(16'(mode), 16'h0006);
		sweep();
		chk_cfg();
		for (int a = 0; a < 128; a++) begin
			v = $random(seed);
			if (a == 7'h0B) v = v & 8'h7F;
			if (a inside {7'h3B, 7'h3C, 7'h3E, 7'h3F}) v = dflt(a);
			put(a, v);
		end
		sweep();
		chk_cfg();
		chk_out(cfg.line_accum_half_cycles, exp_reg[7'h12][15:0]);
		chk_out(cfg.pulse_out2_denominator, exp_reg[7'h2A][15:0]);
		chk_out(16'(cfg.second_current_match), exp_reg[7'h1C][15:0]);
		for (int b = 0; b < 7; b++) begin
			put(7'h0B, 1 << b);
			chk_out(16'(mode), exp_reg[7'h0B][15:0]);
		end
		for (int ch = 0; ch < 2; ch++) begin
			v = $random(seed);
			drive_peak(ch, v[23:0]);
			drive_peak(ch, v[23:1]);
			expect_reg(7'h17 + 2 * ch);
			expect_reg(7'h17 + 2 * ch);
			expect_reg(7'h18 + 2 * ch);
			expect_reg(7'h17 + 2 * ch);
		end
		// Sample in the clearing cycle must survive the clear
		fork
			drive_peak(0, 24'h00FF00);
			expect_reg(7'h18);
		join
		pk[0] = 24'h00FF00;
		expect_reg(7'h17);
		drive_peak(0, 24'h00A5C3);
		drive_peak(1, 24'hC35A00);
		chk_out(pulses[15:0], 16'h0000);
		sfr_core_model_inst.reg_write(7'h0B, 24'h000080 | 24'($random(seed)));
		repeat (2) @(posedge clk_sys);
		for (int a = 0; a < 128; a++) exp_reg[a] = dflt(a);
		pk[0] = 0;
		pk[1] = 0;
		chk_out(pulses[15:0], 16'h0001);
		chk_out(16'(mode), 16'h0006);
		sweep();
		chk_cfg();
		sfr_core_model_inst.sfr_op(8'h91, 1'b0, 8'h00, q);
		chk_val(24'(q), 24'h00007F);
		put(7'h12, 24'h001234);
		put(7'h0B, 24'h000009);
		@(posedge clk_sys);
		#1;
		resetn = 1'b0;
		@(posedge clk_sys);
		#1;
		resetn = 1'b1;
		exp_reg[7'h12] = dflt(7'h12);
		exp_reg[7'h0B] = dflt(7'h0B);
		chk_out(16'(sfr_rdata), 16'h0000);
		chk_cfg();
		chk_out(16'(mode), 16'h0006);
		sfr_core_model_inst.sfr_op(8'h95, 1'b0, 8'h00, q);
		chk_val(24'(q), 24'h000000);
		finish_test();
	end
	// Hang guard
	initial begin
		#5000000;
		failures++;
		finish_test();
	end
endmodule : testbench
